// ==== rtl/result_fifo.sv ====
// Result buffer with valid and ready on both sides
`timescale 1ns/10ps
module result_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 16
) (
	input  wire logic     clk_sys,
	input  wire logic     rst_n,
	result_fifo_if.buffer port
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      count;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_count;
	logic             do_push;
	logic             do_pop;

	// Honest full and empty from the occupancy count
	assign port.push_ready = (count != (AW+1)'(DEPTH));
	assign port.pop_valid  = (count != '0);
	assign port.pop_data   = mem[rd_ptr];

	// Pointer and count update
	always_comb begin
		do_push = port.push_valid && port.push_ready;
		do_pop  = port.pop_valid && port.pop_ready;
		next_wr_ptr = do_push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1) : wr_ptr;
		next_rd_ptr = do_pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1) : rd_ptr;
		next_count = count;
		if (do_push && !do_pop) begin
			next_count = count + 1'b1;
		end else if (do_pop && !do_push) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count  <= next_count;
		end
	end

	// Storage has no reset
	always_ff @(posedge clk_sys) begin
		if (do_push) begin
			mem[wr_ptr] <= port.push_data;
		end
	end
endmodule

// ==== rtl/result_fifo_if.sv ====
// Valid/ready carrier between the converter control and its result buffer
`timescale 1ns/10ps
interface result_fifo_if #(parameter int WIDTH = 16);
	logic [WIDTH-1:0] push_data;
	logic             push_valid;
	logic             push_ready;
	logic [WIDTH-1:0] pop_data;
	logic             pop_valid;
	logic             pop_ready;

	modport buffer (input push_data, input push_valid, output push_ready,
		output pop_data, output pop_valid, input pop_ready);
	modport user (output push_data, output push_valid, input push_ready,
		input pop_data, input pop_valid, output pop_ready);
endinterface

// ==== rtl/sar_conversion_readout.sv ====
// Conversion sequencing and parallel/serial result readout of a 16-bit SAR converter
// What this block does
// - Busy rises within 35 ns of convert start falling.
// - Busy lasts at most 1.45 us except master serial read-after-convert.
// - Parallel result valid on bus within 1.41 us of convert start.
// - Parallel result valid at least 20 ns before busy falls.
// - Master read-during-convert: frame marker about 560 ns after convert start.
// - Master read-after-convert: frame marker about 1.31 us after convert start.
// - Read-after-convert: busy held until frame ends, drops about 25 ns later.
// - Serial clock minimum period 30, 60, 120, 240 ns per divider code.
// - Serial clock maximum period 45, 90, 180, 360 ns per divider code.
// - Serial clock high at least 15, 30, 60, 120 ns per code.
// - Read-after-convert busy max 2.25, 3.00, 4.40, 7.30 us per code.
// - First clock edge 3 ns after frame marker, 20 ns for other codes.
// - Frame marker held after last edge, 5 to 90 ns per code.
// - Chip select low drives serial data within 10 ns in master mode.
// - Chip select low drives serial clock within 10 ns in master mode.
// - Chip select high releases data, marker and clock within 10 ns.
// - Slave mode shifts next bit on each host clock active edge.
// - Each result available when its conversion ends unless the buffer is full (then dropped, overrun set), no pipeline latency.
`timescale 1ns/10ps
module sar_conversion_readout
	import sar_timing_pkg::*;
(
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             convert_start_n,
	input  wire logic             chip_select_n,
	input  wire logic             interface_mode_select,
	input  wire logic             serial_master_select,
	input  wire logic             read_after_convert,
	input  wire logic [1:0]       serial_clock_divider_select,
	input  wire logic [RES_W-1:0] conversion_code,
	output logic                  busy,
	output logic [RES_W-1:0]      data_bus,
	output logic                  data_bus_oe_n,
	output logic                  serial_data_output,
	output logic                  serial_data_output_oe_n,
	output logic                  frame_sync,
	output logic                  frame_sync_oe_n,
	input  wire logic             serial_data_clock_in,
	output logic                  serial_data_clock_out,
	output logic                  serial_data_clock_oe_n,
	output logic                  result_overrun
);
	// Pin synchroniser and stable copies
	logic [PIN_W-1:0] pin_s1;
	logic [PIN_W-1:0] pin_s2;
	logic [PIN_W-1:0] pin_s3;
	logic [PIN_W-1:0] pins;
	logic [PIN_W-1:0] next_pins;
	logic             cnv_fall;
	logic             sclk_fall;
	logic [1:0]       div_code;
	logic             serial_mode;
	logic             master_mode;
	logic             rac_mode;

	// Conversion sequencer state
	conv_state_e      conv_state;
	conv_state_e      next_conv_state;
	logic [TCNT_W-1:0] t_cnt;
	logic [TCNT_W-1:0] next_t_cnt;
	logic             busy_q;
	logic             next_busy_q;
	logic             next_result_overrun;
	logic [RES_W-1:0] next_data_bus;

	// Serial engine state
	ser_state_e       ser_state;
	ser_state_e       next_ser_state;
	logic [RES_W-1:0] shifter;
	logic [RES_W-1:0] next_shifter;
	logic [4:0]       bit_cnt;
	logic [4:0]       next_bit_cnt;
	logic [CNT_W-1:0] div_cnt;
	logic [CNT_W-1:0] next_div_cnt;
	logic             next_sclk;
	logic             next_sync;
	logic             div_tick;
	logic             frame_start;
	logic             slave_pop;

	result_fifo_if #(.WIDTH(RES_W)) fifo ();

	result_fifo #(
		.WIDTH(RES_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_sys(clk_sys),
		.rst_n  (rst_n),
		.port   (fifo.buffer)
	);

	// Divider tables turned into cycle counts
	function automatic logic [CNT_W-1:0] half_cyc(input logic [1:0] code);
		return CNT_W'(cyc_up(SCLK_HIGH_NS[code]));
	endfunction
	function automatic logic [CNT_W-1:0] lead_cyc(input logic [1:0] code);
		return CNT_W'(cyc_up(LEAD_NS[code]));
	endfunction
	function automatic logic [CNT_W-1:0] trail_cyc(input logic [1:0] code);
		return CNT_W'(cyc_up(TRAIL_NS[code]));
	endfunction

	// Three-stage pin synchroniser, a change counts when stages two and three agree
	always_comb begin
		next_pins = (~(pin_s2 ^ pin_s3) & pin_s3) | ((pin_s2 ^ pin_s3) & pins);
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= PIN_RESET;
			pin_s2 <= PIN_RESET;
			pin_s3 <= PIN_RESET;
			pins   <= PIN_RESET;
		end else begin
			pin_s1 <= {serial_data_clock_in, convert_start_n, interface_mode_select,
				serial_master_select, read_after_convert, serial_clock_divider_select};
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pins   <= next_pins;
		end
	end

	// Mode decode and edge detection
	assign div_code    = {pins[P_DIV1], pins[P_DIV0]};
	assign serial_mode = pins[P_SERIAL];
	assign master_mode = pins[P_MASTER];
	assign rac_mode    = pins[P_RAC];
	assign cnv_fall    = pins[P_CNV] && !next_pins[P_CNV];
	assign sclk_fall   = pins[P_SCLK] && !next_pins[P_SCLK];

	// Busy goes high combinationally on the detected edge
	assign busy = busy_q || (cnv_fall && conv_state == CONV_IDLE);

	// Pin drivers follow chip select directly to meet the enable delays
	assign serial_data_output_oe_n = chip_select_n || !serial_mode;
	assign serial_data_clock_oe_n  = chip_select_n || !serial_mode || !master_mode;
	assign frame_sync_oe_n         = chip_select_n || !serial_mode || !master_mode;
	assign data_bus_oe_n           = chip_select_n || serial_mode;
	assign serial_data_output      = shifter[RES_W-1];

	// Conversion sequencer: busy, result capture and parallel bus
	always_comb begin
		next_conv_state     = conv_state;
		next_t_cnt          = t_cnt;
		next_busy_q         = busy_q;
		next_result_overrun = result_overrun;
		next_data_bus       = data_bus;
		fifo.push_valid     = 1'b0;
		fifo.push_data      = conversion_code;
		unique case (conv_state)
			CONV_IDLE: begin
				if (cnv_fall) begin
					next_conv_state = CONV_RUN;
					next_t_cnt      = '0;
					next_busy_q     = 1'b1;
				end
			end
			CONV_RUN: begin
				next_t_cnt = t_cnt + 1'b1;
				if (t_cnt == TCNT_W'(DATA_VALID_CYC)) begin
					fifo.push_valid = 1'b1;
					if (!fifo.push_ready) begin
						next_result_overrun = 1'b1;
					end
				end
				if (t_cnt == TCNT_W'(BUSY_END_CYC)) begin
					if (serial_mode && master_mode && rac_mode && ser_state != SER_IDLE) begin
						next_conv_state = CONV_WAIT_FRAME;
					end else begin
						next_conv_state = CONV_IDLE;
						next_busy_q     = 1'b0;
					end
				end
			end
			CONV_WAIT_FRAME: begin
				if (ser_state == SER_IDLE) begin
					next_conv_state = CONV_IDLE;
					next_busy_q     = 1'b0;
				end
			end
		endcase
		// Parallel mode drains the buffer straight onto the bus
		fifo.pop_ready = 1'b0;
		if (!serial_mode && fifo.pop_valid) begin
			fifo.pop_ready = 1'b1;
			next_data_bus  = fifo.pop_data;
		end else if (frame_start || slave_pop) begin
			fifo.pop_ready = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			conv_state     <= CONV_IDLE;
			t_cnt          <= '0;
			busy_q         <= 1'b0;
			result_overrun <= 1'b0;
			data_bus       <= '0;
		end else begin
			conv_state     <= next_conv_state;
			t_cnt          <= next_t_cnt;
			busy_q         <= next_busy_q;
			result_overrun <= next_result_overrun;
			data_bus       <= next_data_bus;
		end
	end

	// Frame start point depends on read-during or read-after convert
	always_comb begin
		frame_start = 1'b0;
		if (serial_mode && master_mode && conv_state == CONV_RUN && ser_state == SER_IDLE
			&& fifo.pop_valid) begin
			if (rac_mode) begin
				frame_start = (t_cnt == TCNT_W'(SYNC_RAC_CYC));
			end else begin
				frame_start = (t_cnt == TCNT_W'(SYNC_RDC_CYC));
			end
		end
	end

	assign div_tick = (div_cnt == CNT_W'(1));

	// Serial engine: master frames and slave shifting
	always_comb begin
		next_ser_state = ser_state;
		next_shifter   = shifter;
		next_bit_cnt   = bit_cnt;
		next_div_cnt   = (div_cnt > CNT_W'(1)) ? div_cnt - 1'b1 : div_cnt;
		next_sclk      = serial_data_clock_out;
		next_sync      = frame_sync;
		unique case (ser_state)
			SER_IDLE: begin
				if (frame_start) begin
					next_shifter   = fifo.pop_data;
					next_sync      = 1'b1;
					next_div_cnt   = lead_cyc(div_code);
					next_ser_state = SER_LEAD;
				end else if (serial_mode && !master_mode) begin
					if (slave_pop) begin
						next_shifter = fifo.pop_data;
						next_bit_cnt = 5'h10;
					end else if (bit_cnt != '0 && sclk_fall) begin
						next_shifter = {shifter[RES_W-2:0], 1'b0};
						next_bit_cnt = bit_cnt - 1'b1;
					end
				end
			end
			SER_LEAD: begin
				if (div_tick) begin
					next_sclk      = 1'b1;
					next_bit_cnt   = '0;
					next_div_cnt   = half_cyc(div_code);
					next_ser_state = SER_SHIFT;
				end
			end
			SER_SHIFT: begin
				if (div_tick) begin
					next_div_cnt = half_cyc(div_code);
					if (serial_data_clock_out) begin
						next_sclk    = 1'b0;
						next_shifter = {shifter[RES_W-2:0], 1'b0};
						next_bit_cnt = bit_cnt + 1'b1;
						if (bit_cnt == 5'h0F) begin
							next_div_cnt   = trail_cyc(div_code);
							next_ser_state = SER_TRAIL;
						end
					end else begin
						next_sclk = 1'b1;
					end
				end
			end
			SER_TRAIL: begin
				if (div_tick) begin
					next_sync      = 1'b0;
					next_bit_cnt   = '0;
					next_div_cnt   = CNT_W'(SYNC_TO_BUSY_CYC);
					next_ser_state = SER_TAIL;
				end
			end
			SER_TAIL: begin
				if (div_tick) begin
					next_ser_state = SER_IDLE;
				end
			end
			default: begin
				next_ser_state = SER_IDLE;
			end
		endcase
	end

	// Serial engine registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ser_state             <= SER_IDLE;
			shifter               <= '0;
			bit_cnt               <= '0;
			div_cnt               <= '0;
			serial_data_clock_out <= 1'b0;
			frame_sync            <= 1'b0;
		end else begin
			ser_state             <= next_ser_state;
			shifter               <= next_shifter;
			bit_cnt               <= next_bit_cnt;
			div_cnt               <= next_div_cnt;
			serial_data_clock_out <= next_sclk;
			frame_sync            <= next_sync;
		end
	end

	// Slave loading pops the buffer once the shifter has run empty
	assign slave_pop = serial_mode && !master_mode && ser_state == SER_IDLE
		&& bit_cnt == '0 && fifo.pop_valid;
endmodule

// ==== rtl/sar_timing_pkg.sv ====
// Timing constants, tables and state types for the conversion and readout block
package sar_timing_pkg;
	localparam int CLK_NS = 8;                     // 125 MHz system clock period
	localparam int RES_W = 16;                     // Result width
	localparam int FIFO_DEPTH = 16;                // Result buffer depth
	localparam int CNT_W = 8;                      // Serial timer width
	localparam int TCNT_W = 11;                    // Conversion timer width

	// Least time rounds up to whole cycles
	function automatic int cyc_up(input int ns);
		return (ns + CLK_NS - 1) / CLK_NS;
	endfunction

	// Longest time rounds down, never below one cycle
	function automatic int cyc_dn(input int ns);
		return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
	endfunction

	// Conversion phase
	localparam int BUSY_RISE_MAX_NS = 35;
	localparam int BUSY_MAX_NS = 1450;
	localparam int PAR_VALID_MAX_NS = 1410;
	localparam int DATA_VALID_NS = 1300;
	localparam int DATA_VALID_CYC = cyc_dn(DATA_VALID_NS);
	localparam int DATA_TO_BUSY_NS = 20;
	localparam int DATA_TO_BUSY_CYC = cyc_up(DATA_TO_BUSY_NS);
	localparam int BUSY_END_CYC = DATA_VALID_CYC + 1 + DATA_TO_BUSY_CYC;

	// Master serial frame placement
	localparam int SYNC_RDC_NS = 560;
	localparam int SYNC_RDC_CYC = cyc_dn(SYNC_RDC_NS);
	localparam int SYNC_RAC_NS = 1310;
	localparam int SYNC_RAC_CYC = cyc_dn(SYNC_RAC_NS);
	localparam int SYNC_TO_BUSY_NS = 25;
	localparam int SYNC_TO_BUSY_CYC = cyc_dn(SYNC_TO_BUSY_NS);

	// Per divider code: clock high half, lead and trail minimums
	localparam int SCLK_HIGH_NS [4] = '{15, 30, 60, 120};
	localparam int LEAD_NS [4] = '{3, 20, 20, 20};
	localparam int TRAIL_NS [4] = '{5, 7, 35, 90};
	localparam int SCLK_PERIOD_MIN_NS [4] = '{30, 60, 120, 240};
	localparam int SCLK_PERIOD_MAX_NS [4] = '{45, 90, 180, 360};
	localparam int RAC_BUSY_MAX_NS [4] = '{2250, 3000, 4400, 7300};

	// Pin bundle positions after synchronising
	localparam int PIN_W = 7;
	localparam int P_DIV0 = 0;
	localparam int P_DIV1 = 1;
	localparam int P_RAC = 2;
	localparam int P_MASTER = 3;
	localparam int P_SERIAL = 4;
	localparam int P_CNV = 5;
	localparam int P_SCLK = 6;
	localparam logic [PIN_W-1:0] PIN_RESET = 7'h20; // Convert start idles high, host clock low

	typedef enum logic [1:0] {CONV_IDLE, CONV_RUN, CONV_WAIT_FRAME} conv_state_e;
	typedef enum logic [2:0] {SER_IDLE, SER_LEAD, SER_SHIFT, SER_TRAIL, SER_TAIL} ser_state_e;
endpackage

// ==== verification/host_serial_model.sv ====
// Host model: slave clock bursts and capture of serial words
`timescale 1ns/10ps
module host_serial_model
	import sar_timing_pkg::*;
#(
	parameter int HALF = 8
) (
	input  wire logic        clk_sys,
	input  wire logic        burst,
	input  wire logic        clr,
	input  wire logic        serial_data_output,
	input  wire logic        serial_data_output_oe_n,
	input  wire logic        frame_sync,
	input  wire logic        serial_data_clock_out,
	output logic             serial_data_clock_in,
	output logic [RES_W-1:0] word,
	output logic [4:0]       bits
);
	logic mclk_q;
	logic sclk_q;
	logic bit_in;

	// Released line reads back inverted, never its last value
	assign bit_in = serial_data_output_oe_n ? !serial_data_output : serial_data_output;

	// Sixteen host clock pulses per burst, idle low between bursts
	initial begin
		serial_data_clock_in = 1'b0;
		forever begin
			@(posedge clk_sys iff burst);
			repeat (RES_W) begin
				repeat (HALF) @(posedge clk_sys);
				#1 serial_data_clock_in = 1'b1;
				repeat (HALF) @(posedge clk_sys);
				#1 serial_data_clock_in = 1'b0;
			end
		end
	end

	// Capture on the rising edge of whichever clock carries the word
	always @(posedge clk_sys) begin
		mclk_q <= serial_data_clock_out;
		sclk_q <= serial_data_clock_in;
		if (clr)
			bits <= 5'h00;
		else if ((serial_data_clock_out && !mclk_q && frame_sync) || (serial_data_clock_in && !sclk_q)) begin
			word <= {word[RES_W-2:0], bit_in};
			bits <= bits + 5'h01;
		end
	end
endmodule

// ==== verification/sar_readout_asserts.sv ====
// Timing checker on the ports of the conversion and readout block
`timescale 1ns/10ps
module sar_readout_asserts
	import sar_timing_pkg::*;
(
	input wire logic             clk_sys,
	input wire logic             rst_n,
	input wire logic             convert_start_n,
	input wire logic             chip_select_n,
	input wire logic             interface_mode_select,
	input wire logic             serial_master_select,
	input wire logic             read_after_convert,
	input wire logic [1:0]       serial_clock_divider_select,
	input wire logic             busy,
	input wire logic [RES_W-1:0] data_bus,
	input wire logic             data_bus_oe_n,
	input wire logic             serial_data_output_oe_n,
	input wire logic             frame_sync,
	input wire logic             frame_sync_oe_n,
	input wire logic             serial_data_clock_out,
	input wire logic             serial_data_clock_oe_n,
	input wire logic             result_overrun
);
	logic       sclk_q;
	logic       cnv_q;
	logic       seen_rise;
	int         per_cnt;
	int         hi_cnt;
	int         since_fall;
	int         since_start;
	int         busy_cnt;
	logic       rise;
	logic       fall;
	logic       rac;
	logic [1:0] dv;
	int         busy_lim;

	// Edge flags, mode and busy limit
	assign rise = serial_data_clock_out && !sclk_q;
	assign fall = !serial_data_clock_out && sclk_q;
	assign dv = serial_clock_divider_select;
	assign rac = interface_mode_select && serial_master_select && read_after_convert;
	assign busy_lim = rac ? RAC_BUSY_MAX_NS[dv] : BUSY_MAX_NS;

	// Cycle counters for clock, frame and busy timing
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sclk_q <= 1'b0;
			cnv_q <= 1'b1;
			seen_rise <= 1'b0;
			per_cnt <= 0;
			hi_cnt <= 0;
			since_fall <= 0;
			since_start <= 0;
			busy_cnt <= 0;
		end else begin
			sclk_q <= serial_data_clock_out;
			cnv_q <= convert_start_n;
			seen_rise <= frame_sync && (seen_rise || rise);
			per_cnt <= rise ? 1 : per_cnt + 1;
			hi_cnt <= serial_data_clock_out ? hi_cnt + 1 : 0;
			since_fall <= fall ? 1 : since_fall + 1;
			since_start <= (cnv_q && !convert_start_n) ? 1 : since_start + 1;
			busy_cnt <= busy ? busy_cnt + 1 : 0;
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	chk_busy_rise: assert property ($fell(convert_start_n) && !busy |-> ##[1:4] busy)
		else $error("busy late after convert start");
	chk_busy_width: assert property (busy |-> (busy_cnt + 1) * CLK_NS <= busy_lim)
		else $error("busy high too long");
	chk_par_setup: assert property ($fell(busy) && !interface_mode_select |->
		data_bus == $past(data_bus, 1) && data_bus == $past(data_bus, 3))
		else $error("parallel data changed too close to busy fall");
	chk_frame_place: assert property ($rose(frame_sync) |-> (read_after_convert ?
		(since_start inside {[160:176]}) : (since_start inside {[64:80]})))
		else $error("frame marker misplaced");
	chk_rac_hold: assert property (frame_sync && rac |-> busy)
		else $error("busy dropped during frame");
	chk_rac_drop: assert property ($fell(frame_sync) && rac |-> busy ##[2:6] !busy)
		else $error("busy not dropped after frame");
	chk_clk_period: assert property (rise && seen_rise |->
		per_cnt * CLK_NS >= SCLK_PERIOD_MIN_NS[dv] && per_cnt * CLK_NS <= SCLK_PERIOD_MAX_NS[dv])
		else $error("serial clock period out of range");
	chk_clk_high: assert property (fall |-> hi_cnt * CLK_NS >= SCLK_HIGH_NS[dv])
		else $error("serial clock high too short");
	chk_lead_gap: assert property ($rose(frame_sync) |-> !serial_data_clock_out
		##1 (dv == 2'h0 || !serial_data_clock_out) ##1 (dv == 2'h0 || !serial_data_clock_out))
		else $error("clock too soon after frame marker");
	chk_trail_gap: assert property ($fell(frame_sync) |-> since_fall * CLK_NS >= TRAIL_NS[dv])
		else $error("frame marker dropped too soon");
	chk_cs_drive: assert property (!chip_select_n && interface_mode_select &&
		serial_master_select |-> !serial_data_output_oe_n && !frame_sync_oe_n && !serial_data_clock_oe_n)
		else $error("serial pins not driven");
	chk_cs_release: assert property (chip_select_n |-> serial_data_output_oe_n &&
		frame_sync_oe_n && serial_data_clock_oe_n && data_bus_oe_n)
		else $error("pins not released");

	cover property ($fell(busy) && !interface_mode_select);
	cover property ($rose(frame_sync) && read_after_convert);
	cover property ($rose(frame_sync) && !read_after_convert);
	cover property ($rose(result_overrun));
endmodule

bind sar_conversion_readout sar_readout_asserts u_sar_readout_asserts (.clk_sys, .rst_n,
	.convert_start_n, .chip_select_n, .interface_mode_select, .serial_master_select,
	.read_after_convert, .serial_clock_divider_select, .busy, .data_bus, .data_bus_oe_n,
	.serial_data_output_oe_n, .frame_sync, .frame_sync_oe_n, .serial_data_clock_out,
	.serial_data_clock_oe_n, .result_overrun);

// ==== verification/testbench.sv ====
// Self-checking bench for the conversion and readout block
`timescale 1ns/10ps
module testbench
	import sar_timing_pkg::*;
;
	logic             clk_sys;
	logic             rst_n;
	logic             convert_start_n;
	logic             chip_select_n;
	logic             interface_mode_select;
	logic             serial_master_select;
	logic             read_after_convert;
	logic [1:0]       serial_clock_divider_select;
	logic [RES_W-1:0] conversion_code;
	logic             busy;
	logic [RES_W-1:0] data_bus;
	logic             data_bus_oe_n;
	logic             serial_data_output;
	logic             serial_data_output_oe_n;
	logic             frame_sync;
	logic             frame_sync_oe_n;
	logic             serial_data_clock_in;
	logic             serial_data_clock_out;
	logic             serial_data_clock_oe_n;
	logic             result_overrun;
	logic             burst;
	logic             clr;
	logic [RES_W-1:0] word;
	logic [4:0]       bits;
	int               miscompares;
	int               checked;

	sar_conversion_readout u_sar_conversion_readout (.clk_sys, .rst_n, .convert_start_n,
		.chip_select_n, .interface_mode_select, .serial_master_select, .read_after_convert,
		.serial_clock_divider_select, .conversion_code, .busy, .data_bus, .data_bus_oe_n,
		.serial_data_output, .serial_data_output_oe_n, .frame_sync, .frame_sync_oe_n,
		.serial_data_clock_in, .serial_data_clock_out, .serial_data_clock_oe_n, .result_overrun);

	host_serial_model u_host_serial_model (.clk_sys, .burst, .clr, .serial_data_output,
		.serial_data_output_oe_n, .frame_sync, .serial_data_clock_out, .serial_data_clock_in,
		.word, .bits);

	// Free-running system clock
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = !clk_sys;
	end

	task automatic wrap_up();
		if (miscompares == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// Bounded wait for the end of a conversion
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 1200) begin
			tick(1);
			n++;
		end
		if (n == 1200) begin
			miscompares++;
			wrap_up();
		end
		tick(3);
	endtask

	task automatic convert(input logic [RES_W-1:0] code);
		conversion_code = code;
		convert_start_n = 1'b0;
		tick(4);
		check(RES_W'(busy), 16'h0001);
		convert_start_n = 1'b1;
	endtask

	// Mode pins change only with chip select high
	task automatic set_mode(input logic ser, input logic mst, input logic rac, input logic [1:0] dv);
		chip_select_n = 1'b1;
		interface_mode_select = ser;
		serial_master_select = mst;
		read_after_convert = rac;
		serial_clock_divider_select = dv;
		clr = 1'b1;
		tick(5);
		clr = 1'b0;
		chip_select_n = 1'b0;
	endtask

	task automatic test_parallel();
		logic [RES_W-1:0] codes [2];
		codes = '{16'hA5C3, 16'h5A3C};
		set_mode(1'b0, 1'b0, 1'b0, 2'h0);
		foreach (codes[i]) begin
			convert(codes[i]);
			tick(172);
			check(data_bus, codes[i]);
			check(RES_W'(busy), 16'h0000);
		end
	endtask

	task automatic test_master(input logic rac, input logic [1:0] dv, input logic [RES_W-1:0] code,
		input logic [RES_W-1:0] exp, input logic [4:0] nb);
		set_mode(1'b1, 1'b1, rac, dv);
		convert(code);
		wait_idle();
		check(word, exp);
		check(RES_W'(bits), RES_W'(nb));
	endtask

	// Fill the buffer past full, then drain it with stalls between bursts
	task automatic test_slave();
		logic [RES_W-1:0] exp;
		set_mode(1'b1, 1'b0, 1'b0, 2'h0);
		for (int i = 0; i < 17; i++) begin
			convert(16'h1000 + RES_W'(i));
			wait_idle();
			check(RES_W'(result_overrun), RES_W'(i == 16));
		end
		for (int i = 0; i < 17; i++) begin
			exp = (i == 0) ? 16'h4B7D : 16'h0FFF + RES_W'(i);
			clr = 1'b1;
			tick(1);
			clr = 1'b0;
			burst = 1'b1;
			tick(1);
			burst = 1'b0;
			tick(270);
			check(word, exp);
			check(RES_W'(bits), 16'h0010);
		end
	endtask

	// Reset, then the scenarios in order
	initial begin
		miscompares = 0;
		checked = 0;
		rst_n = 1'b0;
		convert_start_n = 1'b1;
		chip_select_n = 1'b1;
		interface_mode_select = 1'b0;
		serial_master_select = 1'b0;
		read_after_convert = 1'b0;
		serial_clock_divider_select = 2'h0;
		conversion_code = 16'h0000;
		burst = 1'b0;
		clr = 1'b1;
		tick(20);
		rst_n = 1'b1;
		tick(4);
		test_parallel();
		for (int d = 0; d < 4; d++) begin
			test_master(1'b1, 2'(d), 16'hC3A5 ^ RES_W'(d), 16'hC3A5 ^ RES_W'(d), 5'h10);
		end
		test_master(1'b0, 2'h0, 16'h9E01, 16'hC3A6, 5'h00);
		test_master(1'b0, 2'h0, 16'h4B7D, 16'h9E01, 5'h10);
		test_slave();
		wrap_up();
	end
endmodule
